// ---- rtl/sireg_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module sireg_top (
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, active low
    // axi4-lite slave
    input wire sireg_pkg::sireg_addr_t s_axi_awaddr, // write address
    input wire logic [2:0] s_axi_awprot, // unused
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire sireg_pkg::sireg_word_t s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte lanes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire sireg_pkg::sireg_addr_t s_axi_araddr, // read address
    input wire logic [2:0] s_axi_arprot, // unused
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output sireg_pkg::sireg_word_t s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    // slave two-wire engine
    input wire logic slave_tx_done, // pulse: transmission finished
    input wire logic first_rx_valid, // pulse: first byte received
    input wire sireg_pkg::sireg_byte_t first_received_byte, // first byte
    input wire logic second_rx_valid, // pulse: second byte received
    input wire sireg_pkg::sireg_byte_t second_received_byte, // second byte
    output sireg_pkg::sireg_byte_t tx_byte, // byte to send to master
    output logic tx_byte_load, // pulse: tx_byte rewritten
    output logic slave_irq, // level slave interrupt
    // master two-wire engine
    input wire logic master_xfer_flag, // master byte-complete flag level
    output logic master_xfer_irq_enable, // enable bit to master engine
    output logic master_irq // level master interrupt
);
    import sireg_pkg::*;

    typedef struct packed {
        logic aw_full;
        sireg_addr_t aw_addr;
        logic w_full;
        sireg_byte_t w_byte;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        sireg_word_t rdata;
        logic [1:0] rresp;
        sireg_byte_t rx1;
        sireg_byte_t rx2;
        sireg_byte_t tx;
        logic tx_load;
        logic m_irq;
    } sireg_top_s;

    localparam sireg_top_s TOP_RST = '{
        aw_full: 1'b0,
        aw_addr: '0,
        w_full: 1'b0,
        w_byte: BYTE_ZERO,
        w_lane0: 1'b0,
        awready: 1'b1,
        wready: 1'b1,
        bvalid: 1'b0,
        bresp: RESP_OKAY,
        arready: 1'b1,
        rvalid: 1'b0,
        rdata: '0,
        rresp: RESP_OKAY,
        rx1: BYTE_ZERO,
        rx2: BYTE_ZERO,
        tx: BYTE_ZERO,
        tx_load: 1'b0,
        m_irq: 1'b0
    };

    sireg_top_s q_r;
    sireg_top_s q_nxt;
    logic do_wr;
    logic wr_ok;

    sireg_flag_if fl ();

    sireg_flags u_flags (
        .aclk(aclk),
        .aresetn(aresetn),
        .fl(fl.unit)
    );

    // shared address reads the second byte, never the transmit byte
    function automatic sireg_byte_t rd_byte(input sireg_idx_t i,
        input sireg_byte_t ctrl, input sireg_byte_t r1, input sireg_byte_t r2);
        sireg_byte_t v;
        v = BYTE_ZERO;
        unique case (i)
            IDX_CTRL: v = ctrl;
            IDX_RX1: v = r1; // RL6
            IDX_RX2_TX: v = r2; // RL7
            default: v = BYTE_ZERO;
        endcase
        return v;
    endfunction : rd_byte

    always_comb begin
        q_nxt = q_r;
        q_nxt.tx_load = 1'b0;
        fl.wr_stb = 1'b0;
        fl.wr_data = q_r.w_byte;
        fl.ev_txd = slave_tx_done;
        fl.ev_rx2 = second_rx_valid;
        fl.ev_rx1 = first_rx_valid;

        // engine captures; software has no write path into these
        if (first_rx_valid) begin
            q_nxt.rx1 = first_received_byte; // RL6
        end
        if (second_rx_valid) begin
            q_nxt.rx2 = second_received_byte; // RL7
        end

        // write address and data are taken in either order
        if (q_r.awready && s_axi_awvalid) begin
            q_nxt.aw_full = 1'b1;
            q_nxt.aw_addr = s_axi_awaddr;
        end
        if (q_r.wready && s_axi_wvalid) begin
            q_nxt.w_full = 1'b1;
            q_nxt.w_byte = s_axi_wdata[7:0];
            q_nxt.w_lane0 = s_axi_wstrb[0];
        end

        // the response channel stalls new writes until it drains
        do_wr = q_r.aw_full && q_r.w_full && !q_r.bvalid;
        wr_ok = sireg_hit(q_r.aw_addr);
        if (do_wr) begin
            q_nxt.aw_full = 1'b0;
            q_nxt.w_full = 1'b0;
            q_nxt.bvalid = 1'b1;
            q_nxt.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
            // byte lane 0 carries the whole 8-bit register
            if (wr_ok && q_r.w_lane0) begin
                unique case (sireg_idx(q_r.aw_addr))
                    IDX_CTRL: fl.wr_stb = 1'b1; // RL1 RL2
                    IDX_RX2_TX: begin
                        q_nxt.tx = q_r.w_byte; // RL7
                        q_nxt.tx_load = 1'b1;
                    end
                    default: ; // read-only first byte ignores writes
                endcase
            end
        end
        if (q_r.bvalid && s_axi_bready) begin
            q_nxt.bvalid = 1'b0;
        end
        q_nxt.awready = !q_nxt.aw_full;
        q_nxt.wready = !q_nxt.w_full;

        // reads answer one cycle after the address is taken
        if (q_r.arready && s_axi_arvalid) begin
            q_nxt.arready = 1'b0;
            q_nxt.rvalid = 1'b1;
            q_nxt.rdata = {24'h000000, rd_byte(sireg_idx(s_axi_araddr),
                fl.ctrl, q_r.rx1, q_r.rx2)};
            q_nxt.rresp = sireg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (q_r.rvalid && s_axi_rready) begin
            q_nxt.rvalid = 1'b0;
            q_nxt.arready = 1'b1;
        end

        q_nxt.m_irq = master_xfer_flag & fl.ctrl[BIT_MASTER_IE]; // RL1
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_r <= TOP_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign s_axi_awready = q_r.awready;
    assign s_axi_wready = q_r.wready;
    assign s_axi_bresp = q_r.bresp;
    assign s_axi_bvalid = q_r.bvalid;
    assign s_axi_arready = q_r.arready;
    assign s_axi_rdata = q_r.rdata;
    assign s_axi_rresp = q_r.rresp;
    assign s_axi_rvalid = q_r.rvalid;
    assign tx_byte = q_r.tx;
    assign tx_byte_load = q_r.tx_load;
    assign slave_irq = fl.irq; // RL8
    assign master_xfer_irq_enable = fl.ctrl[BIT_MASTER_IE]; // RL1
    assign master_irq = q_r.m_irq;
endmodule : sireg_top
`default_nettype wire

// ---- rtl/sireg_pkg.sv ----
// Overview of operation
// RL1: control bit 7 enables master engine interrupt
// RL2: slave interrupt enables, first-byte enable bit 4
// RL3: transmit-done flag bit 2, resets 1, write-0 clears
// RL4: second-byte flag bit 1, resets 0, write-0 clears
// RL5: first-byte flag bit 0, resets 0, write-0 clears
// RL6: first received byte is read-only
// RL7: shared address: read second byte, write transmit byte
// RL8: slave interrupt while enabled flag is set
`default_nettype none
package sireg_pkg;
    localparam int unsigned SIREG_AW = 12;
    localparam int unsigned SIREG_DW = 32;
    typedef logic [SIREG_AW-1:0] sireg_addr_t;
    typedef logic [SIREG_DW-1:0] sireg_word_t;
    typedef logic [7:0] sireg_byte_t;
    typedef logic [9:0] sireg_idx_t;

    // register indices; byte address is four times the index
    localparam sireg_idx_t IDX_CTRL = 10'h0EA;
    localparam sireg_idx_t IDX_RX1 = 10'h0EB;
    localparam sireg_idx_t IDX_RX2_TX = 10'h0EC;
    localparam int unsigned IDX_LSB = 2;

    localparam int unsigned BIT_MASTER_IE = 7;
    localparam int unsigned BIT_TXD_IE = 6;
    localparam int unsigned BIT_RX2_IE = 5;
    localparam int unsigned BIT_RX1_IE = 4;
    localparam int unsigned BIT_TXD_F = 2;
    localparam int unsigned BIT_RX2_F = 1;
    localparam int unsigned BIT_RX1_F = 0;

    localparam sireg_byte_t CTRL_RST = 8'h04;
    localparam sireg_byte_t CTRL_IE_MASK = 8'hF0;
    localparam sireg_byte_t CTRL_FLAG_MASK = 8'h07;
    localparam sireg_byte_t BYTE_ZERO = 8'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic sireg_idx_t sireg_idx(input sireg_addr_t a);
        return a[SIREG_AW-1:IDX_LSB];
    endfunction : sireg_idx

    function automatic logic sireg_hit(input sireg_addr_t a);
        sireg_idx_t i;
        i = a[SIREG_AW-1:IDX_LSB];
        return (a[IDX_LSB-1:0] == 2'h0) &&
            (i == IDX_CTRL || i == IDX_RX1 || i == IDX_RX2_TX);
    endfunction : sireg_hit
endpackage : sireg_pkg
`default_nettype wire

// ---- rtl/sireg_flag_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface sireg_flag_if;
    import sireg_pkg::*;
    logic wr_stb;
    sireg_byte_t wr_data;
    logic ev_txd;
    logic ev_rx2;
    logic ev_rx1;
    sireg_byte_t ctrl;
    logic irq;
    modport host (output wr_stb, output wr_data, output ev_txd, output ev_rx2,
        output ev_rx1, input ctrl, input irq);
    modport unit (input wr_stb, input wr_data, input ev_txd, input ev_rx2,
        input ev_rx1, output ctrl, output irq);
endinterface : sireg_flag_if
`default_nettype wire

// ---- rtl/sireg_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
module sireg_flags (
    input wire logic aclk, // system clock
    input wire logic aresetn, // sync reset, active low
    sireg_flag_if.unit fl // control/status access and events
);
    import sireg_pkg::*;

    typedef struct packed {
        sireg_byte_t ctrl;
        logic irq;
    } sireg_flags_s;

    localparam sireg_flags_s FLAGS_RST = '{ctrl: CTRL_RST, irq: 1'b0}; // RL3

    sireg_flags_s q_r;
    sireg_flags_s q_nxt;

    always_comb begin
        q_nxt = q_r;
        if (fl.wr_stb) begin
            // enables take the written value, flags only clear on zero
            q_nxt.ctrl = (fl.wr_data & CTRL_IE_MASK) | // RL1 RL2
                (q_r.ctrl & fl.wr_data & CTRL_FLAG_MASK); // RL3 RL4 RL5
        end
        // set after clear: an event in the clearing cycle survives
        if (fl.ev_txd) begin
            q_nxt.ctrl[BIT_TXD_F] = 1'b1; // RL3
        end
        if (fl.ev_rx2) begin
            q_nxt.ctrl[BIT_RX2_F] = 1'b1; // RL4
        end
        if (fl.ev_rx1) begin
            q_nxt.ctrl[BIT_RX1_F] = 1'b1; // RL5
        end
        q_nxt.irq = (q_nxt.ctrl[BIT_TXD_IE] & q_nxt.ctrl[BIT_TXD_F]) |
            (q_nxt.ctrl[BIT_RX2_IE] & q_nxt.ctrl[BIT_RX2_F]) |
            (q_nxt.ctrl[BIT_RX1_IE] & q_nxt.ctrl[BIT_RX1_F]); // RL8
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_r <= FLAGS_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign fl.ctrl = q_r.ctrl;
    assign fl.irq = q_r.irq;
endmodule : sireg_flags
`default_nettype wire

// ---- verification/sireg_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module sireg_properties (
    input wire logic aclk, // clock
    input wire logic aresetn, // reset, active low
    input wire sireg_pkg::sireg_word_t s_axi_wdata, // in
    input wire logic s_axi_bvalid, // in
    input wire logic s_axi_arvalid, // in
    input wire logic s_axi_arready, // in
    input wire logic s_axi_rvalid, // in
    input wire logic s_axi_rready, // in
    input wire logic slave_tx_done, // in
    input wire logic first_rx_valid, // in
    input wire logic second_rx_valid, // in
    input wire sireg_pkg::sireg_byte_t tx_byte, // in
    input wire logic tx_byte_load, // in
    input wire logic slave_irq, // in
    input wire logic master_xfer_flag, // in
    input wire logic master_xfer_irq_enable, // in
    input wire logic master_irq // in
);
    import sireg_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_mirq; master_irq == $past(master_xfer_flag && master_xfer_irq_enable); endproperty
    a_mirq: assert property (p_mirq) else $error("master irq mismatch");
    property p_men; $changed(master_xfer_irq_enable) |-> $rose(s_axi_bvalid); endproperty
    a_men: assert property (p_men) else $error("enable moved without a write");
    property p_irq_up;
        $rose(slave_irq) |-> $past(slave_tx_done || first_rx_valid || second_rx_valid)
            || $rose(s_axi_bvalid);
    endproperty
    a_irq_up: assert property (p_irq_up) else $error("irq rose without cause");
    property p_irq_dn; $fell(slave_irq) |-> $rose(s_axi_bvalid); endproperty
    a_irq_dn: assert property (p_irq_dn) else $error("irq fell without a write");
    property p_load; tx_byte_load |-> $rose(s_axi_bvalid) && tx_byte == $past(s_axi_wdata[7:0], 2); endproperty
    a_load: assert property (p_load) else $error("tx byte load wrong");
    property p_txhold; $changed(tx_byte) |-> tx_byte_load; endproperty
    a_txhold: assert property (p_txhold) else $error("tx byte changed silently");
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_rend; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
    a_rend: assert property (p_rend) else $error("read answer repeated");
endmodule : sireg_properties
bind sireg_top sireg_properties u_sireg_properties (.aclk, .aresetn, .s_axi_wdata, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .slave_tx_done,
    .first_rx_valid, .second_rx_valid, .tx_byte, .tx_byte_load, .slave_irq,
    .master_xfer_flag, .master_xfer_irq_enable, .master_irq);
`default_nettype wire

// ---- verification/sireg_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module sireg_partner (
    input wire logic aclk, // clock
    output logic slave_tx_done, // pulse
    output logic first_rx_valid, // pulse
    output logic second_rx_valid, // pulse
    output sireg_pkg::sireg_byte_t rx_byte, // byte for either rx pulse
    output logic master_xfer_flag // master engine flag
);
    import sireg_pkg::*;
    initial begin
        {slave_tx_done, first_rx_valid, second_rx_valid, master_xfer_flag} = 4'h0;
        rx_byte = 8'h00;
    end
    task automatic ev(input int i, input sireg_byte_t b);
        slave_tx_done <= (i == 2);
        second_rx_valid <= (i == 1);
        first_rx_valid <= (i == 0);
        rx_byte <= b;
        @(posedge aclk);
        {slave_tx_done, second_rx_valid, first_rx_valid} <= 3'h0;
        // stale byte inverted so a late capture cannot pass
        rx_byte <= ~b;
        @(posedge aclk);
    endtask : ev
    task automatic mflag(input logic v);
        master_xfer_flag <= v;
    endtask : mflag
endmodule : sireg_partner
`default_nettype wire

// ---- verification/sireg_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module sireg_top_bench;
    import sireg_pkg::*;
    localparam sireg_addr_t A_CT = {IDX_CTRL, 2'h0};
    localparam sireg_addr_t A_R1 = {IDX_RX1, 2'h0};
    localparam sireg_addr_t A_R2 = {IDX_RX2_TX, 2'h0};
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    sireg_addr_t s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    sireg_word_t s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic slave_tx_done, first_rx_valid, second_rx_valid, master_xfer_flag;
    logic tx_byte_load, slave_irq, master_xfer_irq_enable, master_irq;
    sireg_byte_t rx_byte, tx_byte;
    int fail_count = 0;
    int checks_done = 0;
    int i;
    always #50 aclk = ~aclk;
    sireg_top u_sireg_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .slave_tx_done, .first_rx_valid,
        .first_received_byte(rx_byte), .second_rx_valid, .second_received_byte(rx_byte),
        .tx_byte, .tx_byte_load, .slave_irq, .master_xfer_flag, .master_xfer_irq_enable,
        .master_irq);
    sireg_partner u_sireg_partner (.aclk, .slave_tx_done, .first_rx_valid,
        .second_rx_valid, .rx_byte, .master_xfer_flag);
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    task automatic tmo(input int n);
        if (n >= 40) begin
            fail_count++;
            report_and_stop();
        end
    endtask : tmo
    task automatic wr(input sireg_addr_t a, input sireg_byte_t d, input logic [1:0] e);
        int n;
        logic aw, w;
        aw = 1'h0;
        w = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        // bready stays up between writes, so no strobe is rewritten in one step
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_bvalid) break;
            aw |= s_axi_awready;
            w |= s_axi_wready;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
        end
        tmo(n);
        chk(s_axi_bresp, e);
    endtask : wr
    task automatic rd(input sireg_addr_t a, input sireg_byte_t d, input logic [1:0] e);
        int n;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (s_axi_rvalid) break;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        tmo(n);
        chk(s_axi_rdata, {24'h0, d});
        chk(s_axi_rresp, e);
    endtask : rd
    task automatic rst();
        aresetn <= 1'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
    endtask : rst
    initial begin
        rst();
        rd(A_CT, CTRL_RST, RESP_OKAY);
        rd(A_R1, 8'h00, RESP_OKAY);
        rd(12'h000, 8'h00, RESP_SLVERR);
        chk(slave_irq, 1'h0);
        chk(master_xfer_irq_enable, 1'h0);
        $display("test reset values done");
        // bit i: flag i, enable i+4; masked event must stay quiet
        for (i = 0; i < 3; i++) begin
            wr(A_CT, 8'h00, RESP_OKAY);
            rd(A_CT, 8'h00, RESP_OKAY);
            u_sireg_partner.ev(i, sireg_byte_t'(8'hA0 + i));
            chk(slave_irq, 1'h0);
            rd(A_CT, sireg_byte_t'(8'h01 << i), RESP_OKAY);
            wr(A_CT, sireg_byte_t'(8'h11 << i), RESP_OKAY);
            chk(slave_irq, 1'h1);
            wr(A_CT, sireg_byte_t'(8'h10 << i), RESP_OKAY);
            chk(slave_irq, 1'h0);
        end
        $display("test flags done");
        rd(A_R1, 8'hA0, RESP_OKAY);
        wr(A_R1, 8'h5A, RESP_OKAY);
        rd(A_R1, 8'hA0, RESP_OKAY);
        wr(A_R2, 8'h3C, RESP_OKAY);
        chk(tx_byte, 8'h3C);
        chk(tx_byte_load, 1'h1);
        rd(A_R2, 8'hA1, RESP_OKAY);
        chk(tx_byte_load, 1'h0);
        $display("test data done");
        wr(A_CT, 8'h80, RESP_OKAY);
        chk(master_xfer_irq_enable, 1'h1);
        u_sireg_partner.mflag(1'h1);
        repeat (2) @(posedge aclk);
        chk(master_irq, 1'h1);
        wr(A_CT, 8'h00, RESP_OKAY);
        @(posedge aclk);
        chk(master_irq, 1'h0);
        u_sireg_partner.mflag(1'h0);
        s_axi_wstrb <= 4'h0;
        wr(A_CT, 8'h10, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        wr(A_CT + 12'h001, 8'h10, RESP_SLVERR);
        rd(A_CT, 8'h00, RESP_OKAY);
        rst();
        chk(tx_byte, 8'h00);
        chk(master_irq, 1'h0);
        chk(slave_irq, 1'h0);
        rd(A_CT, CTRL_RST, RESP_OKAY);
        rd(A_R1, 8'h00, RESP_OKAY);
        rd(A_R2, 8'h00, RESP_OKAY);
        $display("test master, refusals and reset done");
        report_and_stop();
    end
endmodule : sireg_top_bench
`default_nettype wire
